// >>> rtl/tmc_pkg.sv
// package of constants and carrier types for the match/capture timer
// ----------------------------------------------------------------
// What this block does
// [RULE_01] 32-bit counter advanced through 32-bit prescaler
// [RULE_02] timer mode or external clock counter mode
// [RULE_03] four 32-bit match registers compared to count
// [RULE_04] match may continue counting, optional interrupt
// [RULE_05] match may stop counting, optional interrupt
// [RULE_06] match may reset count to zero
// [RULE_07] shadow match values for glitch-free PWM
// [RULE_08] match may request DMA, optionally
// [RULE_09] four match outputs set low or high
// [RULE_10] four capture registers load count on edges
// [RULE_11] per-channel capture interrupt enable
// [RULE_12] prescaler restarts at terminal, advances count
// [RULE_13] match on equality; shadows load on reset
// ----------------------------------------------------------------
package tmc_pkg;
    localparam int TMC_W = 32;
    localparam int TMC_NCH = 4;
    localparam logic [TMC_W-1:0] TMC_ZERO = 32'h0000_0000;
    localparam logic [TMC_W-1:0] TMC_ONE = 32'h0000_0001;
    localparam logic [TMC_NCH-1:0] TMC_NONE = 4'h0;
    // external output action on match
    typedef enum logic [1:0] {
        TMC_OUT_NOTHING = 2'h0,
        TMC_OUT_LOW = 2'h1,
        TMC_OUT_HIGH = 2'h2,
        TMC_OUT_TOGGLE = 2'h3
    } tmc_out_e;
    // per-channel match configuration
    typedef struct packed {
        logic irq_en;
        logic stop_en;
        logic reset_en;
        logic dma_en;
        tmc_out_e out_act;
    } tmc_match_cfg_s;
    // per-channel capture configuration
    typedef struct packed {
        logic rise_en;
        logic fall_en;
        logic irq_en;
    } tmc_cap_cfg_s;
    // counter run state
    typedef enum logic [2:0] {
        TMC_ST_IDLE = 3'h1,
        TMC_ST_RUN = 3'h2,
        TMC_ST_HALT = 3'h4
    } tmc_state_e;
endpackage

// >>> rtl/tmc_sync.sv
// three-stage synchroniser with agreement-based change detection
`timescale 1ns/1ps
`default_nettype none
module tmc_sync #(
    parameter int WIDTH = 4
) (
    input wire logic CORE_CLK_IN,
    input wire logic NRST_IN,
    input wire logic [WIDTH-1:0] ASYNC_IN,
    output logic [WIDTH-1:0] LEVEL_OUT,
    output logic [WIDTH-1:0] RISE_OUT,
    output logic [WIDTH-1:0] FALL_OUT
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } tmc_sync_s;
    tmc_sync_s st_reg;
    tmc_sync_s st_next;

    // shift chain; level follows once stages two and three agree
    always_comb
    begin
        st_next = st_reg;
        st_next.s1 = ASYNC_IN;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        st_next.lvl = (st_reg.s2 & st_reg.s3) | (st_reg.lvl & ~(~st_reg.s2 & ~st_reg.s3));
    end

    always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // edges are pulses the cycle the agreed level changes
    assign LEVEL_OUT = st_reg.lvl;
    assign RISE_OUT = st_next.lvl & ~st_reg.lvl;
    assign FALL_OUT = ~st_next.lvl & st_reg.lvl;
endmodule
`default_nettype wire

// >>> rtl/tmc_top.sv
// match/capture timer core with prescaler, shadows and pin actions
`timescale 1ns/1ps
`default_nettype none
module tmc_top
    import tmc_pkg::*;
#(
    parameter int NCH = tmc_pkg::TMC_NCH
) (
    input wire logic CORE_CLK_IN,
    input wire logic NRST_IN,
    input wire logic ENABLE_IN,
    input wire logic COUNTER_MODE_IN,
    input wire logic CLEAR_IN,
    input wire logic [tmc_pkg::TMC_W-1:0] PRESCALE_IN,
    input wire logic [tmc_pkg::TMC_W-1:0] MATCH_IN [tmc_pkg::TMC_NCH],
    input wire tmc_pkg::tmc_match_cfg_s MATCH_CFG_IN [tmc_pkg::TMC_NCH],
    input wire tmc_pkg::tmc_cap_cfg_s CAP_CFG_IN [tmc_pkg::TMC_NCH],
    input wire logic EXT_CLK_IN,
    input wire logic [tmc_pkg::TMC_NCH-1:0] CAP_PIN_IN,
    output logic [tmc_pkg::TMC_W-1:0] COUNT_OUT,
    output logic [tmc_pkg::TMC_W-1:0] PRESCALE_COUNT_OUT,
    output logic [tmc_pkg::TMC_W-1:0] CAPTURE_OUT [tmc_pkg::TMC_NCH],
    output logic [tmc_pkg::TMC_NCH-1:0] MATCH_PIN_OUT,
    output logic [tmc_pkg::TMC_NCH-1:0] MATCH_EVT_OUT,
    output logic [tmc_pkg::TMC_NCH-1:0] MATCH_IRQ_OUT,
    output logic [tmc_pkg::TMC_NCH-1:0] DMA_REQ_OUT,
    output logic [tmc_pkg::TMC_NCH-1:0] CAP_IRQ_OUT,
    output logic RUNNING_OUT
);
    import tmc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        tmc_state_e state;
        logic [TMC_W-1:0] count;
        logic [TMC_W-1:0] pre;
        logic [TMC_NCH-1:0][TMC_W-1:0] act;
        logic [TMC_NCH-1:0][TMC_W-1:0] cap;
        logic [TMC_NCH-1:0] pin;
        logic [TMC_NCH-1:0] mevt;
        logic [TMC_NCH-1:0] mirq;
        logic [TMC_NCH-1:0] dma;
        logic [TMC_NCH-1:0] cirq;
    } tmc_core_s;
    tmc_core_s st_reg;
    tmc_core_s st_next;

    logic ext_lvl;
    logic ext_rise;
    logic [TMC_NCH-1:0] cap_rise;
    logic [TMC_NCH-1:0] cap_fall;
    logic tick;
    logic [TMC_NCH-1:0] hit;
    logic [TMC_NCH-1:0] stop_hit;
    logic [TMC_NCH-1:0] rst_hit;
    logic [TMC_NCH-1:0] cap_hit;

    // pin action on match: returns the new output level
    function automatic logic pin_act(input tmc_out_e act, input logic cur);
        logic res;
        res = cur;
        case (act)
            TMC_OUT_LOW: res = 1'b0;
            TMC_OUT_HIGH: res = 1'b1;
            TMC_OUT_TOGGLE: res = ~cur;
            default: res = cur;
        endcase
        return res;
    endfunction

    // packs the shadow values into the active compare copy
    function automatic logic [TMC_NCH-1:0][TMC_W-1:0] shadow_copy(
        input logic [TMC_W-1:0] src [TMC_NCH]);
        logic [TMC_NCH-1:0][TMC_W-1:0] res;
        for (int i = 0; i < TMC_NCH; i++)
        begin
            res[i] = src[i];
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // input synchronisers for count clock and capture pins
    // ------------------------------------------------------------
    tmc_sync #(
        .WIDTH(1)
    ) u_ext_sync (
        .CORE_CLK_IN(CORE_CLK_IN),
        .NRST_IN(NRST_IN),
        .ASYNC_IN(EXT_CLK_IN),
        .LEVEL_OUT(ext_lvl),
        .RISE_OUT(ext_rise),
        .FALL_OUT()
    );

    tmc_sync #(
        .WIDTH(TMC_NCH)
    ) u_cap_sync (
        .CORE_CLK_IN(CORE_CLK_IN),
        .NRST_IN(NRST_IN),
        .ASYNC_IN(CAP_PIN_IN),
        .LEVEL_OUT(),
        .RISE_OUT(cap_rise),
        .FALL_OUT(cap_fall)
    );

    // ------------------------------------------------------------
    // per-channel compare and capture decode
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < TMC_NCH; gi++)
        begin : g_ch
            // equality against the active copy, only while running
            // enable gates the hit so a match never fires while leaving run
            assign hit[gi] = (st_reg.state == TMC_ST_RUN) && ENABLE_IN && tick
                && (st_reg.count == st_reg.act[gi]); // RULE_03 RULE_13
            assign stop_hit[gi] = hit[gi] & MATCH_CFG_IN[gi].stop_en; // RULE_05
            assign rst_hit[gi] = hit[gi] & MATCH_CFG_IN[gi].reset_en; // RULE_06
            assign cap_hit[gi] = (cap_rise[gi] & CAP_CFG_IN[gi].rise_en)
                | (cap_fall[gi] & CAP_CFG_IN[gi].fall_en); // RULE_10
        end
    endgenerate

    // count source: every prescaler wrap, timer or external edges
    assign tick = (st_reg.pre == PRESCALE_IN)
        && (!COUNTER_MODE_IN || ext_rise); // RULE_02 RULE_12

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        st_next.mevt = TMC_NONE;
        st_next.mirq = TMC_NONE;
        st_next.dma = TMC_NONE;
        st_next.cirq = TMC_NONE;
        case (st_reg.state)
            TMC_ST_IDLE:
            begin
                st_next.act = shadow_copy(MATCH_IN); // RULE_07
                if (ENABLE_IN)
                begin
                    st_next.state = TMC_ST_RUN;
                end
            end
            TMC_ST_RUN:
            begin
                if (!ENABLE_IN)
                begin
                    st_next.state = TMC_ST_IDLE;
                end
                else
                begin
                    // prescaler steps on system cycles or external edges
                    if (!COUNTER_MODE_IN || ext_rise)
                    begin
                        st_next.pre = tick ? TMC_ZERO : st_reg.pre + TMC_ONE; // RULE_12
                    end
                    if (tick)
                    begin
                        st_next.count = st_reg.count + TMC_ONE; // RULE_01
                    end
                    if (|rst_hit)
                    begin
                        st_next.count = TMC_ZERO; // RULE_06
                        st_next.act = shadow_copy(MATCH_IN); // RULE_07 RULE_13
                    end
                    if (|stop_hit)
                    begin
                        st_next.count = st_reg.count; // RULE_05
                        st_next.state = TMC_ST_HALT;
                    end
                    for (int i = 0; i < TMC_NCH; i++)
                    begin
                        if (hit[i])
                        begin
                            st_next.mevt[i] = 1'b1; // RULE_04
                            st_next.mirq[i] = MATCH_CFG_IN[i].irq_en; // RULE_04 RULE_05 RULE_06
                            st_next.dma[i] = MATCH_CFG_IN[i].dma_en; // RULE_08
                            st_next.pin[i] = pin_act(MATCH_CFG_IN[i].out_act,
                                st_reg.pin[i]); // RULE_09
                        end
                    end
                end
            end
            TMC_ST_HALT:
            begin
                if (!ENABLE_IN)
                begin
                    st_next.state = TMC_ST_IDLE;
                end
            end
            default:
            begin
                st_next.state = TMC_ST_IDLE;
            end
        endcase
        // captures work in every state
        for (int i = 0; i < TMC_NCH; i++)
        begin
            if (cap_hit[i])
            begin
                st_next.cap[i] = st_reg.count; // RULE_10
                st_next.cirq[i] = CAP_CFG_IN[i].irq_en; // RULE_11
            end
        end
        // synchronous clear of count and prescaler, reloads shadows
        if (CLEAR_IN)
        begin
            st_next.count = TMC_ZERO;
            st_next.pre = TMC_ZERO;
            st_next.act = shadow_copy(MATCH_IN); // RULE_13
            if (st_reg.state == TMC_ST_HALT)
            begin
                st_next.state = ENABLE_IN ? TMC_ST_RUN : TMC_ST_IDLE;
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            st_reg <= '0;
            st_reg.state <= TMC_ST_IDLE;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // outputs come straight from the state register
    assign COUNT_OUT = st_reg.count;
    assign PRESCALE_COUNT_OUT = st_reg.pre;
    assign MATCH_PIN_OUT = st_reg.pin;
    assign MATCH_EVT_OUT = st_reg.mevt;
    assign MATCH_IRQ_OUT = st_reg.mirq;
    assign DMA_REQ_OUT = st_reg.dma;
    assign CAP_IRQ_OUT = st_reg.cirq;
    assign RUNNING_OUT = (st_reg.state == TMC_ST_RUN);
    generate
        for (gi = 0; gi < TMC_NCH; gi++)
        begin : g_cap_out
            assign CAPTURE_OUT[gi] = st_reg.cap[gi];
        end
    endgenerate

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_timer_tick;
        RUNNING_OUT && ENABLE_IN && !CLEAR_IN && !COUNTER_MODE_IN
            && (PRESCALE_COUNT_OUT == PRESCALE_IN) && !(|hit);
    endsequence

    AST_COUNT_STEP: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN) // RULE_01
        s_timer_tick |=> COUNT_OUT == $past(COUNT_OUT) + TMC_ONE)
        else $error("count did not advance on prescaler wrap");

    AST_PRE_WRAP: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN) // RULE_12
        s_timer_tick |=> PRESCALE_COUNT_OUT == TMC_ZERO)
        else $error("prescaler did not restart at terminal");

    AST_PRE_HOLD: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN) // RULE_12
        RUNNING_OUT && ENABLE_IN && !CLEAR_IN && !tick && !(|hit)
            |=> COUNT_OUT == $past(COUNT_OUT))
        else $error("count moved without a prescaler wrap");

    AST_EXT_MODE: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN) // RULE_02
        COUNTER_MODE_IN && !ext_rise && !CLEAR_IN |=> $stable(PRESCALE_COUNT_OUT))
        else $error("counter mode stepped without external edge");

    AST_MATCH_EVT: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN) // RULE_03
        hit[0] |=> MATCH_EVT_OUT[0])
        else $error("match event missing");

    AST_MATCH_IRQ: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN) // RULE_04
        hit[1] && MATCH_CFG_IN[1].irq_en |=> MATCH_IRQ_OUT[1])
        else $error("match interrupt missing");

    AST_STOP: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN) // RULE_05
        (|stop_hit) && !CLEAR_IN |=> !RUNNING_OUT ##1 $stable(COUNT_OUT) || CLEAR_IN)
        else $error("stop on match did not halt");

    AST_RESET: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN) // RULE_06
        (|rst_hit) && !(|stop_hit) |=> COUNT_OUT == TMC_ZERO)
        else $error("reset on match did not clear count");

    AST_SHADOW: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN) // RULE_07
        (|rst_hit) |=> st_reg.act[2] == $past(MATCH_IN[2]))
        else $error("shadow not loaded on counter reset");

    AST_DMA: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN) // RULE_08
        DMA_REQ_OUT[0] |-> $past(hit[0]) && $past(MATCH_CFG_IN[0].dma_en))
        else $error("dma request without enabled match");

    AST_PIN_HIGH: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN) // RULE_09
        hit[2] && MATCH_CFG_IN[2].out_act == TMC_OUT_HIGH |=> MATCH_PIN_OUT[2])
        else $error("match output not driven high");

    AST_CAPTURE: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN) // RULE_10
        cap_hit[0] |=> CAPTURE_OUT[0] == $past(COUNT_OUT))
        else $error("capture did not load count");

    AST_CAP_IRQ: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN) // RULE_11
        CAP_IRQ_OUT[1] |-> $past(cap_hit[1]) && $past(CAP_CFG_IN[1].irq_en))
        else $error("capture interrupt without enabled event");
endmodule
`default_nettype wire

// >>> dv/tmc_far_end.sv
// far-side model driving the count clock and capture pins
`timescale 1ns/1ps
`default_nettype none
module tmc_far_end (
    input wire logic clk_in,
    output logic ext_clk_out,
    output logic [3:0] cap_pin_out
);
    // pins idle low until a test moves them
    initial
    begin
        ext_clk_out = 1'b0;
        cap_pin_out = 4'h0;
    end
    // slow external clock, each level held for half cycles
    task automatic ext_pulses(input int n, input int half);
        repeat (n)
        begin
            repeat (half) @(posedge clk_in);
            ext_clk_out <= 1'b1;
            repeat (half) @(posedge clk_in);
            ext_clk_out <= 1'b0;
        end
    endtask
    // capture pin levels change at a clock edge
    task automatic set_pins(input logic [3:0] v);
        @(posedge clk_in);
        cap_pin_out <= v;
    endtask
endmodule
`default_nettype wire

// >>> dv/tmc_top_bench.sv
// self-checking bench for the match/capture timer
`timescale 1ns/1ps
`default_nettype none
module tmc_top_bench;
    import tmc_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic enable = 1'b0;
    logic cmode = 1'b0;
    logic clear = 1'b0;
    logic [TMC_W-1:0] prescale = 32'h0;
    logic [TMC_W-1:0] match [TMC_NCH] = '{default: 32'hFFFF_FFFF};
    tmc_match_cfg_s mcfg [TMC_NCH] = '{default: 6'h0};
    tmc_cap_cfg_s ccfg [TMC_NCH] = '{3'h5, 3'h4, 3'h3, 3'h1};
    logic ext_clk;
    logic [3:0] cap_pin;
    logic [TMC_W-1:0] count, pcount, c0;
    logic [TMC_W-1:0] capture [TMC_NCH];
    logic [3:0] mpin, mevt, mirq, dreq, cirq;
    logic running;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    int n, b1, d1;
    int n_irq [4] = '{default: 0};
    int n_dma [4] = '{default: 0};
    int n_cap [4] = '{default: 0};
    tmc_top i_tmc_top (.CORE_CLK_IN(clk), .NRST_IN(nrst), .ENABLE_IN(enable),
        .COUNTER_MODE_IN(cmode), .CLEAR_IN(clear), .PRESCALE_IN(prescale),
        .MATCH_IN(match), .MATCH_CFG_IN(mcfg), .CAP_CFG_IN(ccfg), .EXT_CLK_IN(ext_clk),
        .CAP_PIN_IN(cap_pin), .COUNT_OUT(count), .PRESCALE_COUNT_OUT(pcount),
        .CAPTURE_OUT(capture), .MATCH_PIN_OUT(mpin), .MATCH_EVT_OUT(mevt),
        .MATCH_IRQ_OUT(mirq), .DMA_REQ_OUT(dreq), .CAP_IRQ_OUT(cirq),
        .RUNNING_OUT(running));
    tmc_far_end i_tmc_far_end (.clk_in(clk), .ext_clk_out(ext_clk), .cap_pin_out(cap_pin));
    // 200 MHz clock
    always #2.5 clk = ~clk;
    // pulse tally and hang guard
    always @(posedge clk)
    begin
        for (int i = 0; i < 4; i++)
        begin
            n_irq[i] += (mirq[i] === 1'b1);
            n_dma[i] += (dreq[i] === 1'b1);
            n_cap[i] += (cirq[i] === 1'b1);
        end
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // edges until the match event of channel ch shows
    task automatic wait_evt(input int ch, output int k);
        k = 0;
        do
        begin
            tick(1);
            k++;
        end while (mevt[ch] !== 1'b1 && k < 300);
    endtask
    function automatic tmc_match_cfg_s mc(input logic [3:0] f, input tmc_out_e a);
        return tmc_match_cfg_s'({f, a});
    endfunction
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        tick(1);
        chk(count, 32'h0);
        chk({28'h0, mpin}, 32'h0);
        chk(capture[0], 32'h0);
        chk({31'h0, running}, 32'h0);
        $display("test reset done");
        @(posedge clk);
        match[0] <= 32'h2;
        match[1] <= 32'h1;
        match[2] <= 32'h1;
        match[3] <= 32'h2;
        mcfg[0] <= mc(4'hB, TMC_OUT_HIGH);
        mcfg[1] <= mc(4'h8, TMC_OUT_NOTHING);
        mcfg[2] <= mc(4'h0, TMC_OUT_HIGH);
        mcfg[3] <= mc(4'h1, TMC_OUT_LOW);
        enable <= 1'b1;
        wait_evt(0, n);
        chk(count, 32'h0);
        chk({28'h0, mpin}, 32'h5);
        chk({28'h0, mirq}, 32'h1);
        chk({28'h0, dreq}, 32'h9);
        b1 = n_irq[1];
        d1 = n_dma[1];
        wait_evt(0, n);
        chk(32'(n), 32'h3);
        chk(32'(n_irq[1] - b1), 32'h1);
        chk(32'(n_dma[1] - d1), 32'h0);
        chk(32'(n_irq[3]), 32'h0);
        $display("test match actions done");
        @(posedge clk);
        match[0] <= 32'h4;
        wait_evt(0, n);
        chk(32'(n), 32'h2);
        wait_evt(0, n);
        chk(32'(n), 32'h5);
        $display("test shadow done");
        @(posedge clk);
        mcfg[0] <= mc(4'hC, TMC_OUT_LOW);
        wait_evt(0, n);
        chk(count, 32'h4);
        chk({31'h0, mpin[0]}, 32'h0);
        chk({31'h0, running}, 32'h0);
        tick(10);
        chk(count, 32'h4);
        @(posedge clk);
        clear <= 1'b1;
        @(posedge clk);
        clear <= 1'b0;
        tick(0);
        chk(count, 32'h0);
        tick(2);
        chk({31'h0, running}, 32'h1);
        $display("test stop done");
        @(posedge clk);
        for (int i = 0; i < 4; i++)
            mcfg[i] <= mc(4'h0, tmc_out_e'((i == 1) ? TMC_OUT_TOGGLE : TMC_OUT_NOTHING));
        prescale <= 32'h3;
        clear <= 1'b1;
        @(posedge clk);
        clear <= 1'b0;
        tick(5);
        c0 = count;
        tick(8);
        chk(c0, 32'h1);
        chk(count, 32'h3);
        chk({31'h0, mpin[1]}, 32'h1);
        chk({31'h0, pcount < 32'h4}, 32'h1);
        $display("test prescale done");
        @(posedge clk);
        cmode <= 1'b1;
        prescale <= 32'h1;
        clear <= 1'b1;
        @(posedge clk);
        clear <= 1'b0;
        i_tmc_far_end.ext_pulses(6, 6);
        tick(10);
        chk(count, 32'h3);
        chk({31'h0, mpin[1]}, 32'h0);
        $display("test counter mode done");
        i_tmc_far_end.set_pins(4'hF);
        tick(10);
        chk(capture[0], 32'h3);
        chk(capture[1], 32'h3);
        chk(capture[3], 32'h0);
        chk(32'(n_cap[0]), 32'h1);
        chk(32'(n_cap[1]), 32'h0);
        i_tmc_far_end.ext_pulses(2, 6);
        i_tmc_far_end.set_pins(4'h0);
        tick(10);
        chk(capture[2], 32'h4);
        chk(capture[0], 32'h3);
        chk(32'(n_cap[2]), 32'h1);
        chk(32'(n_cap[3]), 32'h0);
        $display("test capture done");
        summarize();
    end
endmodule
`default_nettype wire
